// file: logic/biphase_tx_map.svh
// constants of the biphase transmitter serial input stage
// Functional notes
// - left-justified, I2S and right-justified framing each take 16, 18, 20 or 24 bit words.
// - data is sampled at each rising bit clock edge and changes at the falling edge.
// - in right-justified framing a high frame clock is left and a low one is right.
// - right-justified at 64 bit clocks a frame, the msb comes 32 minus width after the edge.
// - I2S is the default framing, with a low frame clock for left and a high one for right.
// - in I2S the msb comes one bit clock after each frame clock transition.
// - left-justified framing has high for left, low for right, and no msb delay.
// - a separate oversampling clock is divided by an integer to make the biphase clock.
// - oversampling runs at 256, 384, 512 or 768 times the frame rate, matched by the divider.
`ifndef BIPHASE_TX_MAP_SVH
`define BIPHASE_TX_MAP_SVH
`define SAMPLE_BITS 24
`define HALF_FRAME_SLOTS 6'h20
`define SLOT_MAX 6'h3f
`define FIFO_DEPTH 8
`define WIDTH_16 6'h10
`define WIDTH_18 6'h12
`define WIDTH_20 6'h14
`define WIDTH_24 6'h18
`define DIV_256 3'h2
`define DIV_384 3'h3
`define DIV_512 3'h4
`define DIV_768 3'h6
`endif

// file: logic/biphase_tx_pkg.sv
// types of the biphase transmitter serial input stage
package biphase_tx_pkg;
  typedef enum logic [1:0] {fmt_i2s, fmt_left_just, fmt_right_just} fmt_t;
  typedef enum logic [1:0] {word_16, word_18, word_20, word_24} width_sel_t;
  typedef enum logic [1:0] {ratio_256, ratio_384, ratio_512, ratio_768} ratio_sel_t;
  typedef logic [23:0] sample_t;
endpackage

// file: logic/sample_fifo.sv
// flop based fifo with valid and ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // pointers wrap by index so any depth works, not only powers of two
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr_ff + 1'b1);
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr_ff + 1'b1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff <= '0;
    end else if (push && !pop) begin
      count_ff <= count_ff + 1'b1;
    end else if (pop && !push) begin
      count_ff <= count_ff - 1'b1;
    end
  end
endmodule // sample_fifo

// file: logic/biphase_tx_serial_input_formatter.sv
// serial audio input formatter and biphase clock divider
`timescale 1ns/1ps
`include "biphase_tx_map.svh"
module biphase_tx_serial_input_formatter (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic bit_clk_pin,
  input wire logic frame_clk_pin,
  input wire logic serial_data_pin,
  input wire logic oversample_tx_clock,
  input wire biphase_tx_pkg::fmt_t format_sel,
  input wire biphase_tx_pkg::width_sel_t width_sel,
  input wire biphase_tx_pkg::ratio_sel_t ratio_sel,
  output biphase_tx_pkg::sample_t left_sample,
  output biphase_tx_pkg::sample_t right_sample,
  output logic sample_valid,
  input wire logic sample_ready,
  output logic overrun_pulse,
  output logic biphase_tick,
  output logic biphase_clk
);
  import biphase_tx_pkg::*;

  function automatic logic [5:0] word_bits(input width_sel_t sel);
    case (sel)
      word_16: word_bits = `WIDTH_16;
      word_18: word_bits = `WIDTH_18;
      word_20: word_bits = `WIDTH_20;
      default: word_bits = `WIDTH_24;
    endcase
  endfunction

  // slot of the msb counted from the frame clock edge
  function automatic logic [5:0] msb_slot(input fmt_t fmt, input width_sel_t sel);
    case (fmt)
      fmt_left_just: msb_slot = 6'h00;
      fmt_right_just: msb_slot = `HALF_FRAME_SLOTS - word_bits(sel);
      default: msb_slot = 6'h01;
    endcase
  endfunction

  function automatic logic is_left(input fmt_t fmt, input logic lr);
    case (fmt)
      fmt_i2s: is_left = !lr;
      default: is_left = lr;
    endcase
  endfunction

  function automatic logic [2:0] div_of(input ratio_sel_t sel);
    case (sel)
      ratio_256: div_of = `DIV_256;
      ratio_384: div_of = `DIV_384;
      ratio_512: div_of = `DIV_512;
      default: div_of = `DIV_768;
    endcase
  endfunction

  // all four inputs come from outside the ref_clk domain
  logic [3:0] raw_in;
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  assign raw_in = {oversample_tx_clock, serial_data_pin, frame_clk_pin, bit_clk_pin};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_sync
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          sync1_ff[g] <= 1'b0;
          sync2_ff[g] <= 1'b0;
        end else begin
          sync1_ff[g] <= raw_in[g];
          sync2_ff[g] <= sync1_ff[g];
        end
      end
    end
  endgenerate

  logic bclk_s;
  logic lr_s;
  logic sdata_s;
  logic osclk_s;
  assign bclk_s = sync2_ff[0];
  assign lr_s = sync2_ff[1];
  assign sdata_s = sync2_ff[2];
  assign osclk_s = sync2_ff[3];

  logic bclk_prev_ff;
  logic osclk_prev_ff;
  logic bclk_rise;
  logic osclk_rise;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bclk_prev_ff <= 1'b0;
      osclk_prev_ff <= 1'b0;
    end else begin
      bclk_prev_ff <= bclk_s;
      osclk_prev_ff <= osclk_s;
    end
  end
  assign bclk_rise = bclk_s && !bclk_prev_ff;
  assign osclk_rise = osclk_s && !osclk_prev_ff;

  // slot counter within the half frame, restarted by each frame clock edge
  logic lr_prev_ff;
  logic [5:0] slot_ff;
  logic [5:0] nxt_slot;
  logic [5:0] first_slot;
  logic [5:0] last_slot;
  logic in_word;
  logic word_done;
  assign nxt_slot = (lr_s != lr_prev_ff) ? 6'h00 :
                    (slot_ff == `SLOT_MAX) ? `SLOT_MAX : 6'(slot_ff + 1'b1);
  assign first_slot = msb_slot(format_sel, width_sel);
  assign last_slot = 6'(first_slot + word_bits(width_sel) - 1'b1);
  // slots outside the word window are dropped, so long frames are harmless in I2S and left-justified framing
  assign in_word = bclk_rise && (nxt_slot >= first_slot) && (nxt_slot <= last_slot);
  assign word_done = in_word && (nxt_slot == last_slot);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lr_prev_ff <= 1'b0;
      slot_ff <= `SLOT_MAX;
    end else if (bclk_rise) begin
      lr_prev_ff <= lr_s;
      slot_ff <= nxt_slot;
    end
  end

  logic [23:0] shift_ff;
  logic [23:0] nxt_shift;
  logic [23:0] aligned_word;
  assign nxt_shift = {shift_ff[22:0], sdata_s};
  // msb aligned so every width lands the same way in the 24 bit sample
  assign aligned_word = 24'(nxt_shift << (6'(`SAMPLE_BITS) - word_bits(width_sel)));

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_ff <= 24'h0000;
    end else if (in_word) begin
      shift_ff <= nxt_shift;
    end
  end

  logic [23:0] left_word_ff;
  logic left_have_ff;
  logic push_valid;
  logic push_ready;
  logic [47:0] push_data;
  assign push_valid = word_done && !is_left(format_sel, lr_s) && left_have_ff;
  assign push_data = {left_word_ff, aligned_word};

  // a right word with no left partner is dropped to keep channels paired
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      left_word_ff <= 24'h0000;
      left_have_ff <= 1'b0;
    end else if (word_done) begin
      if (is_left(format_sel, lr_s)) begin
        left_word_ff <= aligned_word;
        left_have_ff <= 1'b1;
      end else begin
        left_have_ff <= 1'b0;
      end
    end
  end

  // no stall exists toward the serial source, so a full fifo loses the pair
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      overrun_pulse <= 1'b0;
    end else begin
      overrun_pulse <= push_valid && !push_ready;
    end
  end

  logic [47:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready;
  sample_fifo #(
    .WIDTH(48),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_data(push_data),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );

  // holding registers facing the encoder
  logic hold_valid_ff;
  assign fifo_ready = !hold_valid_ff || sample_ready;
  assign sample_valid = hold_valid_ff;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_valid_ff <= 1'b0;
      left_sample <= 24'h0000;
      right_sample <= 24'h0000;
    end else if (fifo_ready) begin
      hold_valid_ff <= fifo_valid;
      if (fifo_valid) begin
        left_sample <= fifo_data[47:24];
        right_sample <= fifo_data[23:0];
      end
    end
  end

  // divide by ratio/128 to get two biphase cells per bit at 64 bits per frame
  logic [2:0] div_cnt_ff;
  logic [2:0] div_n;
  assign div_n = div_of(ratio_sel);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_ff <= 3'h0;
      biphase_tick <= 1'b0;
      biphase_clk <= 1'b0;
    end else begin
      biphase_tick <= 1'b0;
      if (osclk_rise) begin
        if (div_cnt_ff >= 3'(div_n - 1'b1)) begin
          div_cnt_ff <= 3'h0;
          biphase_tick <= 1'b1;
          biphase_clk <= !biphase_clk;
        end else begin
          div_cnt_ff <= 3'(div_cnt_ff + 1'b1);
        end
      end
    end
  end
endmodule // biphase_tx_serial_input_formatter

// file: sim/formatter_props.sv
// port checks for the serial input formatter
`timescale 1ns/1ps
module formatter_props (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic oversample_tx_clock,
  input wire biphase_tx_pkg::width_sel_t width_sel,
  input wire biphase_tx_pkg::sample_t left_sample,
  input wire biphase_tx_pkg::sample_t right_sample,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic overrun_pulse,
  input wire logic biphase_tick,
  input wire logic biphase_clk
);
  import biphase_tx_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  AST_TICK_PULSE: assert property (biphase_tick |=> !biphase_tick)
    else $error("tick too wide");
  // pin must stay high two cycles so the sync delay stays inside the window
  AST_TICK_CAUSE: assert property (biphase_tick |-> $past(oversample_tx_clock, 2))
    else $error("tick without oversample edge");
  AST_CLK_TOGGLE: assert property (biphase_tick |-> ##[0:1] $changed(biphase_clk))
    else $error("biphase clock missed a tick");
  AST_CLK_CAUSE: assert property ($changed(biphase_clk) |->
    biphase_tick || $past(biphase_tick))
    else $error("biphase clock moved alone");
  AST_VALID_STANDS: assert property (sample_valid && !sample_ready |=>
    sample_valid && $stable(left_sample) && $stable(right_sample))
    else $error("held pair changed");
  AST_MASK_16: assert property (sample_valid && width_sel == word_16 |->
    left_sample[7:0] == 8'h00 && right_sample[7:0] == 8'h00)
    else $error("extra bits kept at 16");
  AST_MASK_20: assert property (sample_valid && width_sel == word_20 |->
    left_sample[3:0] == 4'h0 && right_sample[3:0] == 4'h0)
    else $error("extra bits kept at 20");
  AST_OVR_FULL: assert property (overrun_pulse |-> sample_valid)
    else $error("overrun with empty hold");
  AST_OVR_PULSE: assert property (overrun_pulse |=> !overrun_pulse)
    else $error("overrun too wide");
  cover property (sample_valid && sample_ready);
  cover property (overrun_pulse);
  cover property (biphase_tick);
endmodule // formatter_props
bind biphase_tx_serial_input_formatter formatter_props i_props (.ref_clk, .rst_b,
  .oversample_tx_clock, .width_sel, .left_sample, .right_sample, .sample_valid,
  .sample_ready, .overrun_pulse, .biphase_tick, .biphase_clk);

// file: sim/audio_source.sv
// behavioural upstream serial audio source
`timescale 1ns/1ps
module audio_source (
  input wire logic ref_clk,
  output logic bclk,
  output logic lrclk,
  output logic sdata
);
  import biphase_tx_pkg::*;
  initial begin
    bclk = 1'b0;
    lrclk = 1'b1;
    sdata = 1'b0;
  end
  // a lead-in slot at the right level forces a frame edge even after a format change
  task automatic send_frame(input fmt_t f, input int w, input sample_t l, input sample_t r);
    int msb;
    int idx;
    logic lv;
    msb = (f == fmt_left_just) ? 0 : (f == fmt_i2s) ? 1 : 32 - w;
    lv = (f != fmt_i2s);
    for (int s = -1; s < 64; s++) begin
      @(negedge ref_clk);
      bclk = 1'b0;
      lrclk = (s >= 0 && s < 32) ? lv : !lv;
      idx = s % 32 - msb;
      // data moves on the falling bit clock; slots outside the word keep changing
      if (s >= 0 && idx >= 0 && idx < w) sdata = (s < 32) ? l[23 - idx] : r[23 - idx];
      else sdata = !sdata;
      repeat (2) @(negedge ref_clk);
      bclk = 1'b1;
      repeat (2) @(negedge ref_clk);
    end
    bclk = 1'b0;
  endtask
endmodule // audio_source

// file: sim/tb_biphase_tx_serial_input_formatter.sv
// self-checking bench for the serial input formatter
`timescale 1ns/1ps
module tb_biphase_tx_serial_input_formatter;
  import biphase_tx_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ovs_clk = 1'b0;
  fmt_t format_sel = fmt_i2s;
  width_sel_t width_sel = word_16;
  ratio_sel_t ratio_sel = ratio_256;
  logic sample_ready = 1'b0;
  logic bit_clk, frame_clk, sdata, sample_valid, overrun_pulse, biphase_tick, biphase_clk;
  sample_t left_sample, right_sample;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int ovr_cnt = 0;
  int pops = 0;
  int ticks = 0;
  localparam sample_t L_WORD = 24'ha5_c3f1;
  localparam sample_t R_WORD = 24'h5a_3c0e;
  initial forever #50 ref_clk = !ref_clk;
  audio_source i_src (.ref_clk(ref_clk), .bclk(bit_clk), .lrclk(frame_clk), .sdata(sdata));
  biphase_tx_serial_input_formatter i_dut (.ref_clk, .rst_b, .bit_clk_pin(bit_clk),
    .frame_clk_pin(frame_clk), .serial_data_pin(sdata), .oversample_tx_clock(ovs_clk),
    .format_sel, .width_sel, .ratio_sel, .left_sample, .right_sample, .sample_valid,
    .sample_ready, .overrun_pulse, .biphase_tick, .biphase_clk);
  task automatic final_report();
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (overrun_pulse === 1'b1) ovr_cnt++;
    if (sample_valid === 1'b1 && sample_ready === 1'b1) pops++;
    if (biphase_tick === 1'b1) ticks++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (8) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic t_formats();
    int w;
    int k;
    logic [23:0] m;
    for (int f = 0; f < 3; f++) begin
      for (int i = 0; i < 4; i++) begin
        w = (i == 3) ? 24 : 16 + 2 * i;
        m = 24'hff_ffff << (24 - w);
        format_sel = fmt_t'(f);
        width_sel = width_sel_t'(i);
        i_src.send_frame(fmt_t'(f), w, L_WORD, R_WORD);
        k = 0;
        while (sample_valid !== 1'b1 && k < 400) begin
          @(negedge ref_clk);
          k++;
        end
        check(left_sample, L_WORD & m);
        check(right_sample, R_WORD & m);
        sample_ready = 1'b1;
        @(negedge ref_clk);
        sample_ready = 1'b0;
        repeat (3) @(negedge ref_clk);
        check(24'(sample_valid), 24'h00_0000);
      end
    end
  endtask
  // encoder stalls while ten pairs arrive: eight in the fifo, one held, one lost
  task automatic t_overrun();
    width_sel = word_24;
    format_sel = fmt_i2s;
    ovr_cnt = 0;
    for (int n = 0; n < 10; n++) i_src.send_frame(fmt_i2s, 24, L_WORD, R_WORD);
    repeat (10) @(negedge ref_clk);
    check(24'(ovr_cnt), 24'h00_0001);
    pops = 0;
    sample_ready = 1'b1;
    repeat (40) @(negedge ref_clk);
    sample_ready = 1'b0;
    check(24'(pops), 24'h00_0009);
  endtask
  task automatic t_divider();
    int nd;
    for (int r = 0; r < 4; r++) begin
      nd = (r == 3) ? 6 : r + 2;
      ratio_sel = ratio_sel_t'(r);
      do_reset();
      ticks = 0;
      repeat (12) begin
        ovs_clk = 1'b1;
        repeat (5) @(negedge ref_clk);
        ovs_clk = 1'b0;
        repeat (5) @(negedge ref_clk);
      end
      check(24'(ticks), 24'(12 / nd));
      check(24'(biphase_clk), 24'((12 / nd) % 2));
    end
  endtask
  initial begin
    do_reset();
    t_formats();
    t_overrun();
    t_divider();
    final_report();
  end
endmodule // tb_biphase_tx_serial_input_formatter
